// file: rtl/pcarr_top.sv
// Counter array top: time base, five modules, Avalon-MM registers
//
// What this block does
// - Mode field picks div12, div4, T0, pin
// - Mode bit 0 enables overflow interrupt
// - Timer 0 overflows counted only while run set
// - Time base counts only while run set
// - Overflow sets counter overflow flag bit 7
// - Control holds run, overflow, five flags
// - Rising capture copies time base, sets flag
// - Falling capture copies time base, sets flag
// - Both capture bits capture either edge
// - Match without toggle: flag only, software timer
// - Match with toggle inverts module pin
// - Pulse width mode drives 8-bit PWM
// - Module four watchdog needs enable bit
// - Reserved mode bits written zero, read zero
// - Time base may keep counting in idle
// - Watchdog match raises internal reset and sets flag bit 4
// - Watchdog enable sits at mask 40H
`timescale 1ns/1ns
`default_nettype none
module pcarr_top #(
    parameter int MODULES = 5
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Pins and chip signals
    input wire logic [4:0] MODULE_PINS_IN,
    output logic [4:0] MODULE_PINS_OUT,
    output logic [4:0] MODULE_PINS_OE,
    input wire logic EXT_COUNT_PIN,
    input wire logic T0_OVERFLOW,
    input wire logic CPU_IDLE,
    // Results
    output logic IRQ,
    output logic WDT_RESET
);
    import pcarr_pkg::*;
    pcarr_req_s req;
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;
    logic [15:0] count;
    logic [3:0] presc;
    logic [1:0] ext_sync;
    logic [1:0] pin_sync [MODULES];
    logic ext_prev;
    logic ack;
    logic [7:0] mm_reg [MODULES];
    logic [15:0] cmp_reg [MODULES];
    logic [15:0] cap_reg [MODULES];
    logic [MODULES-1:0] ev_set;
    logic [MODULES-1:0] cap_load;
    logic [MODULES-1:0] wdt_hits;
    logic [MODULES-1:0] pin_o;
    logic [31:0] rdata;
    assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                   writedata: AVS_WRITEDATA};
    // Time base source selection
    wire [1:0] src = mode_reg[MODE_SRC_LSB +: 2];
    wire idle_hold = CPU_IDLE && mode_reg[MODE_IDLE_STOP_BIT];
    wire run = ctrl_reg[CTRL_RUN_BIT] && !idle_hold;
    wire ext_edge = ext_sync[1] && !ext_prev;
    wire presc_end12 = (presc == DIV12_COUNT - 4'h1);
    wire presc_end4 = (presc == DIV4_COUNT - 4'h1);
    logic src_pulse;
    always_comb begin
        unique case (src)
            SRC_DIV12: src_pulse = presc_end12;
            SRC_DIV4: src_pulse = presc_end4;
            SRC_T0OVF: src_pulse = T0_OVERFLOW;
            SRC_EXT: src_pulse = ext_edge;
        endcase
    end
    wire tick = run && src_pulse;
    wire overflow = tick && (count == 16'hFFFF);
    // Bus decode
    wire wr = req.write && ack;
    wire [2:0] widx = 3'(req.address[4:2]);
    wire wr_mode = wr && (req.address == OFS_MODE);
    wire wr_ctrl = wr && (req.address == OFS_CTRL);
    wire wr_count = wr && (req.address == OFS_COUNT);
    wire wr_mm = wr && (req.address[7:5] == OFS_MOD_MODE[7:5]) && (widx < 3'd5);
    wire wr_cmp = wr && (req.address[7:5] == OFS_MOD_CMP[7:5]) && (widx < 3'd5);
    // One wait cycle per access, answer at second edge
    assign AVS_WAITREQUEST = (req.read || req.write) && !ack;
    // Prescaler, count pin synchroniser, acknowledge
    always_ff @(posedge CLK) begin
        if (RST) begin
            presc <= 4'h0;
            ext_sync <= 2'b00;
            ext_prev <= 1'b0;
            ack <= 1'b0;
        end else begin
            presc <= (presc_end12 || (src == SRC_DIV4 && presc_end4)) ? 4'h0 : presc + 4'h1;
            ext_sync <= {ext_sync[0], EXT_COUNT_PIN};
            ext_prev <= ext_sync[1];
            ack <= (req.read || req.write) && !ack;
        end
    end
    // Mode register and time base
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_reg <= MODE_RESET;
            count <= 16'h0000;
        end else begin
            if (wr_mode) begin
                mode_reg <= req.writedata[7:0] & MODE_MASK;
            end
            if (wr_count) begin
                count <= req.writedata[15:0];
            end else if (tick) begin
                count <= count + 16'h0001;
            end
        end
    end
    // Control register: set wins over software clear
    logic [7:0] next_ctrl;
    always_comb begin
        next_ctrl = wr_ctrl ? req.writedata[7:0] & 8'hDF : ctrl_reg;
        if (overflow) begin
            next_ctrl[CTRL_OVF_BIT] = 1'b1;
        end
        next_ctrl[4:0] = next_ctrl[4:0] | ev_set;
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= next_ctrl;
        end
    end
    // Per-module registers and instances
    genvar g;
    generate
        for (g = 0; g < MODULES; g++) begin : g_mod
            pcarr_mm_s mm;
            assign mm = '{cmp: mm_reg[g][MM_CMP_BIT], rise: mm_reg[g][MM_RISE_BIT],
                          fall: mm_reg[g][MM_FALL_BIT], mat: mm_reg[g][MM_MAT_BIT],
                          tog: mm_reg[g][MM_TOG_BIT], pwm: mm_reg[g][MM_PWM_BIT],
                          ie: mm_reg[g][MM_IE_BIT]};
            always_ff @(posedge CLK) begin
                if (RST) begin
                    mm_reg[g] <= MM_RESET;
                    cmp_reg[g] <= CMP_RESET;
                    pin_sync[g] <= 2'b00;
                end else begin
                    pin_sync[g] <= {pin_sync[g][0], MODULE_PINS_IN[g]};
                    if (wr_mm && widx == 3'(g)) begin
                        mm_reg[g] <= req.writedata[7:0] & MM_MASK;
                    end
                    if (wr_cmp && widx == 3'(g)) begin
                        cmp_reg[g] <= req.writedata[15:0];
                    end
                end
            end
            pcarr_module #(
                .IS_WDT(g == 4)
            ) u_mod (
                .clk(CLK),
                .rst(RST),
                .mode(mm),
                .cmp_value(cmp_reg[g]),
                .wdt_enable(mode_reg[MODE_WDT_BIT]),
                .count(count),
                .count_tick(tick),
                .pin_in(pin_sync[g][1]),
                .capture(cap_reg[g]),
                .capture_load(cap_load[g]),
                .event_set(ev_set[g]),
                .pin_out(pin_o[g]),
                .wdt_hit(wdt_hits[g])
            );
            assign MODULE_PINS_OE[g] = mm.cmp && (mm.pwm || (mm.mat && mm.tog));
        end
    endgenerate
    assign MODULE_PINS_OUT = pin_o;
    // Interrupt request from enabled flags
    logic [MODULES-1:0] mod_ie;
    always_comb begin
        for (int i = 0; i < MODULES; i++) begin
            mod_ie[i] = mm_reg[i][MM_IE_BIT];
        end
    end
    assign IRQ = (ctrl_reg[CTRL_OVF_BIT] && mode_reg[MODE_OVF_IE_BIT])
                 || |(ctrl_reg[4:0] & mod_ie);
    // Internal watchdog reset pulse
    always_ff @(posedge CLK) begin
        if (RST) begin
            WDT_RESET <= 1'b0;
        end else begin
            WDT_RESET <= |wdt_hits;
        end
    end
    // Read mux
    always_comb begin
        rdata = 32'h0000_0000;
        if (req.address == OFS_MODE) begin
            rdata = {24'h000000, mode_reg};
        end else if (req.address == OFS_CTRL) begin
            rdata = {24'h000000, ctrl_reg};
        end else if (req.address == OFS_COUNT) begin
            rdata = {16'h0000, count};
        end else if (req.address[7:5] == OFS_MOD_MODE[7:5] && widx < 3'd5) begin
            rdata = {24'h000000, mm_reg[widx]};
        end else if (req.address[7:5] == OFS_MOD_CMP[7:5] && widx < 3'd5) begin
            rdata = {16'h0000, cmp_reg[widx]};
        end else if (req.address[7:5] == OFS_MOD_CAP[7:5] && widx < 3'd5) begin
            rdata = {16'h0000, cap_reg[widx]};
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (req.read && !ack) begin
            AVS_READDATA <= rdata;
        end
    end
endmodule : pcarr_top
`default_nettype wire

// file: rtl/pcarr_pkg.sv
// Package for the counter array: register map, field positions, types
package pcarr_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MOD_MODE = 8'h20;
    localparam logic [7:0] OFS_MOD_CMP = 8'h40;
    localparam logic [7:0] OFS_MOD_CAP = 8'h60;
    // Array mode register fields
    localparam int MODE_OVF_IE_BIT = 0;
    localparam int MODE_SRC_LSB = 1;
    localparam int MODE_WDT_BIT = 6;
    localparam int MODE_IDLE_STOP_BIT = 7;
    localparam logic [7:0] MODE_MASK = 8'hCF;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Array control register fields
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_OVF_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Module mode register fields
    localparam int MM_IE_BIT = 0;
    localparam int MM_PWM_BIT = 1;
    localparam int MM_TOG_BIT = 2;
    localparam int MM_MAT_BIT = 3;
    localparam int MM_FALL_BIT = 4;
    localparam int MM_RISE_BIT = 5;
    localparam int MM_CMP_BIT = 6;
    localparam logic [7:0] MM_MASK = 8'h7F;
    localparam logic [7:0] MM_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    // Count source codes of the mode register
    localparam logic [1:0] SRC_DIV12 = 2'h0;
    localparam logic [1:0] SRC_DIV4 = 2'h1;
    localparam logic [1:0] SRC_T0OVF = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam logic [3:0] DIV12_COUNT = 4'hC;
    localparam logic [3:0] DIV4_COUNT = 4'h4;
    // External count pin: least spacing of counted edges
    localparam real EXT_MIN_NS = 660.0;
    localparam real CLK_NS = 100.0;
    localparam int EXT_MIN_CYCLES = (EXT_MIN_NS / CLK_NS) > 1.0 ? 7 : 1;
    // Per-module mode decoded
    typedef struct packed {
        logic cmp;
        logic rise;
        logic fall;
        logic mat;
        logic tog;
        logic pwm;
        logic ie;
    } pcarr_mm_s;
    // Avalon request carrier
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } pcarr_req_s;
endpackage : pcarr_pkg

// file: rtl/pcarr_module.sv
// One capture/compare module of the counter array
`timescale 1ns/1ns
`default_nettype none
module pcarr_module #(
    parameter bit IS_WDT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire pcarr_pkg::pcarr_mm_s mode,
    input wire logic [15:0] cmp_value,
    input wire logic wdt_enable,
    // Time base
    input wire logic [15:0] count,
    input wire logic count_tick,
    // Synchronised pin input
    input wire logic pin_in,
    // Results
    output logic [15:0] capture,
    output logic capture_load,
    output logic event_set,
    output logic pin_out,
    output logic wdt_hit
);
    import pcarr_pkg::*;
    logic pin_prev;
    logic [7:0] cmp_low;
    wire rise_edge = pin_in && !pin_prev;
    wire fall_edge = !pin_in && pin_prev;
    wire is_capture = !mode.cmp && (mode.rise || mode.fall);
    wire cap_hit = is_capture && ((mode.rise && rise_edge) || (mode.fall && fall_edge));
    wire is_match = mode.cmp && mode.mat && !mode.pwm;
    wire match_hit = is_match && count_tick && (count == cmp_value);
    wire is_pwm = mode.cmp && mode.pwm && !mode.mat;
    wire low_roll = count_tick && (count[7:0] == 8'hFF);
    // Capture on chosen edges, flag compare matches
    assign capture_load = cap_hit;
    assign event_set = cap_hit || match_hit;
    assign wdt_hit = IS_WDT && match_hit && wdt_enable;
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev <= 1'b0;
            capture <= 16'h0000;
        end else begin
            pin_prev <= pin_in;
            if (cap_hit) begin
                capture <= count;
            end
        end
    end
    // Pin drive: toggle on match or PWM level; duty byte reloads at low-byte rollover
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= 1'b1;
            cmp_low <= 8'h00;
        end else begin
            if (low_roll) begin
                cmp_low <= cmp_value[15:8];
            end
            if (is_pwm) begin
                pin_out <= (count[7:0] > cmp_low);
            end else if (match_hit && mode.tog) begin
                pin_out <= !pin_out;
            end
        end
    end
endmodule : pcarr_module
`default_nettype wire

// file: tb/pcarr_monitor.sv
// Port-level checker for the counter array
`timescale 1ns/1ns
`default_nettype none
module pcarr_monitor (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Outputs
    input wire logic [4:0] MODULE_PINS_OUT,
    input wire logic [4:0] MODULE_PINS_OE,
    input wire logic IRQ,
    input wire logic WDT_RESET
);
    import pcarr_pkg::*;
    logic [7:0] mode;
    logic [7:0] mm [5];
    logic [4:0] drives;
    logic [4:0] ies;
    wire logic wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
    wire logic armed = mode[MODE_WDT_BIT] && mm[4][MM_CMP_BIT] && mm[4][MM_MAT_BIT];
    // Shadow copies of the mode registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode <= MODE_RESET;
            mm <= '{default: MM_RESET};
        end else if (wr_ok && AVS_ADDRESS == OFS_MODE) begin
            mode <= AVS_WRITEDATA[7:0] & MODE_MASK;
        end else if (wr_ok && AVS_ADDRESS[7:5] == 3'h1 && AVS_ADDRESS[4:2] < 3'h5) begin
            mm[AVS_ADDRESS[4:2]] <= AVS_WRITEDATA[7:0] & MM_MASK;
        end
    end
    // Which modules drive their pin, which may interrupt
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            drives[i] = mm[i][MM_CMP_BIT]
                        && (mm[i][MM_PWM_BIT] || (mm[i][MM_MAT_BIT] && mm[i][MM_TOG_BIT]));
            ies[i] = mm[i][MM_IE_BIT];
        end
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    property p_wait;
        $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_rdmask;
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_MODE
            |-> AVS_READDATA[31:8] == 24'h0 && AVS_READDATA[5:4] == 2'h0;
    endproperty
    a_rdmask: assert property (p_rdmask) else $error("reserved mode bits set");
    property p_irq;
        IRQ |-> mode[MODE_OVF_IE_BIT] || (|ies);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enable");
    property p_oe;
        MODULE_PINS_OE == drives;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_quiet;
        ((MODULE_PINS_OUT ^ $past(MODULE_PINS_OUT)) & ~$past(drives)) == 5'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle pin moved");
    property p_wden;
        WDT_RESET |-> $past(armed);
    endproperty
    a_wden: assert property (p_wden) else $error("reset without enable");
    property p_wdpulse;
        WDT_RESET |=> !WDT_RESET;
    endproperty
    a_wdpulse: assert property (p_wdpulse) else $error("reset pulse long");
    property p_rstval;
        $fell(RST) |-> MODULE_PINS_OUT == 5'h1F && !IRQ && !WDT_RESET;
    endproperty
    a_rstval: assert property (p_rstval) else $error("reset state wrong");
endmodule : pcarr_monitor
`default_nettype wire

// file: tb/pcarr_pins.sv
// Far-side model: module pins, count pin, timer 0 overflow
`timescale 1ns/1ns
`default_nettype none
module pcarr_pins (
    // Clock
    input wire logic clk,
    // Lines toward the array
    output logic [4:0] pins,
    output logic ext_pin,
    output logic t0_ovf
);
    initial begin
        pins = 5'h00;
        ext_pin = 1'b0;
        t0_ovf = 1'b0;
    end
    // Single-cycle overflow pulses with gaps
    task automatic t0(input int k);
        repeat (k) begin
            @(posedge clk) t0_ovf <= 1'b1;
            @(posedge clk) t0_ovf <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : t0
    // Count edges nine periods apart
    task automatic ext(input int k);
        repeat (k) begin
            @(posedge clk) ext_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : ext
    // Set one module pin and let it settle
    task automatic pin(input int i, input logic v);
        @(posedge clk) pins[i] <= v;
        repeat (6) @(posedge clk);
    endtask : pin
endmodule : pcarr_pins
`default_nettype wire

// file: tb/pcarr_top_tb.sv
// Self-checking bench for the counter array
`timescale 1ns/1ns
`default_nettype none
module pcarr_top_tb;
    import pcarr_pkg::*;
    pcarr_req_s req;
    logic clk, rst, idle, irq, wdt, waitreq, ext, t0;
    logic [31:0] rdata;
    logic [4:0] pin_in, pin_out, pin_oe;
    logic [31:0] expq [$];
    logic [15:0] v;
    int fails = 0, samples_checked = 0, seed = 4851, wdt_seen = 0, n;
    pcarr_top pcarr_top_inst (.CLK(clk), .RST(rst), .AVS_ADDRESS(req.address),
        .AVS_READ(req.read), .AVS_WRITE(req.write), .AVS_WRITEDATA(req.writedata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .MODULE_PINS_IN(pin_in),
        .MODULE_PINS_OUT(pin_out), .MODULE_PINS_OE(pin_oe), .EXT_COUNT_PIN(ext),
        .T0_OVERFLOW(t0), .CPU_IDLE(idle), .IRQ(irq), .WDT_RESET(wdt));
    pcarr_pins pcarr_pins_inst (.clk(clk), .pins(pin_in), .ext_pin(ext), .t0_ovf(t0));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count mismatches and comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // One transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{address: a, read: !w, write: w, writedata: d};
        for (int i = 0; i <= 20; i++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
            if (i == 20) fails++;
            if (i == 20) give_verdict();
        end
        req <= '0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Read results against the oldest note; watchdog pulses counted
    always @(posedge clk) begin
        if (req.read === 1'b1 && waitreq === 1'b0) chk(rdata, expq.pop_front());
        if (wdt === 1'b1) wdt_seen++;
    end
    initial begin
        req = '0;
        rst = 1'b1;
        idle = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_MODE, 0);
        rd(OFS_CTRL, 0);
        rd(8'hFC, 0);
        bus(1, OFS_MODE, 32'hFF);
        rd(OFS_MODE, {24'h0, MODE_MASK});
        // Every count source, ending in an overflow
        for (int s = 0; s < 4; s++) begin
            // Run window is 120 edges: 10 slow or 30 fast ticks, overflow before the read
            n = (s == 0) ? 9 : (s == 1) ? 28 : 1 + ($random(seed) & 3);
            bus(1, OFS_MODE, 2 * s + 1);
            repeat (8) @(posedge clk);
            bus(1, OFS_COUNT, {16'h0, 16'h0 - 16'(n)});
            bus(1, OFS_CTRL, 32'h40);
            if (s < 2) repeat (114) @(posedge clk);
            else if (s == 2) pcarr_pins_inst.t0(n);
            else pcarr_pins_inst.ext(n);
            rd(OFS_CTRL, 32'hC0);
            chk(irq, 1);
            bus(1, OFS_CTRL, 0);
            chk(irq, 0);
            rd(OFS_COUNT, (s == 0) ? 1 : (s == 1) ? 2 : 0);
        end
        // Rising, falling and both-edge capture
        for (int j = 0; j < 3; j++) begin
            v = $random(seed);
            bus(1, OFS_COUNT, v);
            bus(1, OFS_MOD_MODE + 8'(4 * j), (j == 2) ? 32'h30 : 32'h20 >> j);
            pcarr_pins_inst.pin(j, 1'b1);
            bus(1, OFS_COUNT, v + 16'h1);
            pcarr_pins_inst.pin(j, 1'b0);
            rd(OFS_MOD_CAP + 8'(4 * j), (j == 0) ? v : v + 16'h1);
            rd(OFS_CTRL, 1 << j);
            bus(1, OFS_CTRL, 0);
        end
        // Idle stop: run set but no counting while idle
        bus(1, OFS_MODE, 32'h82);
        bus(1, OFS_COUNT, 32'h0);
        bus(1, OFS_CTRL, 32'h40);
        repeat (8) @(posedge clk);
        rd(OFS_COUNT, 0);
        idle <= 1'b0;
        // Pulse width on module 2: duty byte taken at rollover
        bus(1, OFS_MOD_CMP + 8'h8, 32'h8000);
        bus(1, OFS_MOD_MODE + 8'h8, 32'h42);
        bus(1, OFS_COUNT, 32'hFF);
        repeat (8) @(posedge clk);
        bus(1, OFS_CTRL, 32'h0);
        chk(pin_out[2], 0);
        bus(1, OFS_COUNT, 32'hC0);
        @(posedge clk);
        chk(pin_out[2], 1);
        bus(1, OFS_COUNT, 32'h40);
        @(posedge clk);
        chk(pin_out[2], 0);
        // Toggle output, software timer, then watchdog
        bus(1, OFS_MOD_CMP + 8'hC, 32'h10);
        bus(1, OFS_MOD_CMP + 8'h10, 32'h10);
        bus(1, OFS_MOD_MODE + 8'hC, 32'h4C);
        bus(1, OFS_MOD_MODE + 8'h10, 32'h48);
        for (int k = 0; k < 2; k++) begin
            bus(1, OFS_MODE, 32'h02 | (k << 6));
            bus(1, OFS_COUNT, 32'hC);
            bus(1, OFS_CTRL, 32'h40);
            repeat (40) @(posedge clk);
            rd(OFS_CTRL, 32'h58);
            bus(1, OFS_CTRL, 0);
            chk(wdt_seen, k);
            chk(pin_out, k ? 5'h1B : 5'h13);
            chk(pin_oe, 5'h0C);
            chk(irq, 0);
            rd(OFS_CTRL, 0);
        end
        give_verdict();
    end
endmodule : pcarr_top_tb
bind pcarr_top pcarr_monitor pcarr_monitor_inst (.CLK(CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .MODULE_PINS_OUT(MODULE_PINS_OUT),
    .MODULE_PINS_OE(MODULE_PINS_OE), .IRQ(IRQ), .WDT_RESET(WDT_RESET));
`default_nettype wire
